// *** bench/snv_link_asserts.sv ***
// Link checker for the host and device ends
`timescale 1ns/1ps
`default_nettype none
module snv_link_asserts (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic so_o,
   input wire logic so_oe
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // ==========
   // Framing and clock shape
   a_first_edge: assert property ($fell(cs_n) |-> !sck[*8] ##1 sck)
      else $error("first clock edge misplaced");
   a_sck_high: assert property ($rose(sck) |-> sck[*8] ##1 !sck)
      else $error("clock high phase wrong");
   a_sck_low: assert property ($fell(sck) && !cs_n |-> !sck[*8])
      else $error("clock low phase short");
   a_sck_idle: assert property (cs_n |-> !sck)
      else $error("clock moves while deselected");
   a_cs_gap: assert property ($rose(cs_n) |-> cs_n[*8])
      else $error("select gap short");
   // ==========
   // Data lines
   a_si_hold: assert property (sck && $past(sck) |-> $stable(si))
      else $error("input data moved in high phase");
   a_so_hold: assert property (so_oe && $past(so_oe) && sck && $past(sck)
      |-> $stable(so_o))
      else $error("output data moved in high phase");
   a_so_release: assert property (cs_n[*8] |-> !so_oe)
      else $error("output driven while deselected");
   c_read: cover property ($rose(so_oe));
   c_frame: cover property ($rose(cs_n));
   c_sck: cover property ($rose(sck));
endmodule // snv_link_asserts
`default_nettype wire

// *** bench/tb_top.sv ***
// Bench: host and device ends joined over the link
`timescale 1ns/1ps
`default_nettype none
module tb_top import snv_pkg::*;;
   logic clk_sys = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
   logic mem_we = 0, busy_in = 0, autosave_o, pready, pslverr, rx_stb, err;
   logic [7:0] paddr = 0, mem_wdata = 0, rx_byte, status_o, nv_status_o;
   logic [16:0] mem_addr = 0;
   logic [31:0] pwdata = 0, prdata, rd, lf = 32'h2344;
   logic [7:0] mm [logic [16:0]];
   logic [7:0] q [$];
   int n_fail = 0, samples_checked = 0, cyc = 0;
   snv_link_if lnk ();
   snv_host u_snv_host (.clk_sys, .rstn, .paddr, .psel, .penable, .pwrite,
      .pwdata, .prdata, .pready, .pslverr, .link(lnk), .rx_byte, .rx_stb);
   // Store busy driven by the bench so that read holding is exercised
   snv_dev u_snv_dev (.clk_sys, .rstn, .link(lnk), .mem_we, .mem_addr,
      .mem_wdata, .busy_in, .status_o, .nv_status_o, .autosave_o);
   snv_link_asserts u_snv_link_asserts (.clk_sys, .rstn, .cs_n(lnk.cs_n),
      .sck(lnk.sck), .si(lnk.si), .so_o(lnk.so_o), .so_oe(lnk.so_oe));
   always #25 clk_sys = ~clk_sys;
   // ==========
   // Tasks
   function automatic logic [31:0] nx(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'h0;
   endtask
   // Pin level is written after start; low pin falls mid data byte
   task automatic cmd(input logic [7:0] op, input logic [16:0] a,
         input logic [7:0] len, input logic [7:0] tx, input logic wp);
      // Status write data byte also strobes in; released output reads 0
      if (op == STATUS_WRITE_CMD) q.push_back(8'h00);
      apb(1'b1, REG_ADDR, {15'h0, a});
      apb(1'b1, REG_TXDATA, {24'h0, tx});
      apb(1'b1, REG_CTRL, {15'h0, 1'b1, len, op});
      if (!wp) repeat (180) @(posedge clk_sys);
      apb(1'b1, REG_PINS, {31'h0, wp});
      do apb(1'b0, REG_STAT, 32'h0); while (rd[STAT_DONE] !== 1'b1);
   endtask
   task automatic rdm(input logic [7:0] op, input logic [16:0] a, input int n);
      for (int i = 0; i < n; i++) q.push_back(mm[17'(a + 17'(i))]);
      cmd(op, a, 8'(n), 8'h00, 1'b1);
   endtask
   task automatic wm(input logic [16:0] a, input logic upd);
      lf = nx(lf);
      @(posedge clk_sys);
      {mem_we, mem_addr, mem_wdata} <= {1'b1, a, lf[7:0]};
      if (upd) mm[a] = lf[7:0];
      @(posedge clk_sys);
      mem_we <= 1'b0;
   endtask
   // ==========
   // Checkers and timeout
   always @(posedge clk_sys) begin
      if (rstn && rx_stb === 1'b1) begin
         chk("rx_byte", q.size() > 0 ? q.pop_front() : 8'hXX, rx_byte);
      end
   end
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 60000) begin
         n_fail++;
         results();
      end
   end
   // ==========
   // Main sequence
   initial begin
      repeat (10) @(posedge clk_sys);
      rstn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         wm(i < 3 ? 17'h1FFFE + 17'(i) : 17'h17FFC + 17'(i), 1'b1);
      end
      chk("status", SR_RESET, status_o);
      rdm(READ_CMD, 17'h1FFFE, 3);
      rdm(FAST_READ_CMD, 17'h1FFFF, 2);
      apb(1'b0, 8'h20, 32'h0);
      chk("pslverr", 8'h01, {7'h0, err});
      $display("test reads done");
      cmd(STATUS_WRITE_CMD, 17'h0, 8'h01, 8'hFF, 1'b1);
      chk("status", 8'h00, status_o);
      cmd(SET_WRITE_LATCH_CMD, 17'h0, 8'h00, 8'h00, 1'b1);
      chk("status", 8'h02, status_o);
      cmd(CLEAR_WRITE_LATCH_CMD, 17'h0, 8'h00, 8'h00, 1'b1);
      chk("status", 8'h00, status_o);
      cmd(SET_WRITE_LATCH_CMD, 17'h0, 8'h00, 8'h00, 1'b1);
      apb(1'b1, REG_PINS, 32'h0);
      cmd(STATUS_WRITE_CMD, 17'h0, 8'h01, 8'hFF, 1'b0);
      chk("status", 8'hCC, status_o);
      chk("nv status", 8'h00, nv_status_o);
      $display("test latch done");
      wm(17'h00000, 1'b0);
      rdm(READ_CMD, 17'h00000, 1);
      cmd(SET_WRITE_LATCH_CMD, 17'h0, 8'h00, 8'h00, 1'b0);
      cmd(STATUS_WRITE_CMD, 17'h0, 8'h01, 8'h84, 1'b0);
      chk("status", 8'hCC, status_o);
      cmd(SET_WRITE_LATCH_CMD, 17'h0, 8'h00, 8'h00, 1'b1);
      cmd(STATUS_WRITE_CMD, 17'h0, 8'h01, 8'h84, 1'b0);
      chk("status", 8'hC4, status_o);
      wm(17'h17FFF, 1'b1);
      wm(17'h18000, 1'b0);
      rdm(READ_CMD, 17'h17FFF, 2);
      $display("test protect done");
      cmd(SET_WRITE_LATCH_CMD, 17'h0, 8'h00, 8'h00, 1'b1);
      cmd(STORE_CMD, 17'h0, 8'h00, 8'h00, 1'b1);
      chk("nv status", 8'hC4, nv_status_o);
      chk("status", 8'hC4, status_o);
      q.push_back(8'hC4);
      cmd(STATUS_READ_CMD, 17'h0, 8'h01, 8'h00, 1'b1);
      $display("test store done");
      busy_in <= 1'b1;
      q.push_back(mm[17'h17FFF]);
      apb(1'b1, REG_ADDR, 32'h00017FFF);
      apb(1'b1, REG_CTRL, {15'h0, 1'b1, 8'h01, READ_CMD});
      repeat (40) @(posedge clk_sys);
      apb(1'b0, REG_STAT, 32'h0);
      chk("stat", 8'h05, rd[7:0]);
      chk("status", 8'hC5, status_o);
      chk("cs_n", 8'h01, {7'h0, lnk.cs_n});
      busy_in <= 1'b0;
      do apb(1'b0, REG_STAT, 32'h0); while (rd[STAT_DONE] !== 1'b1);
      $display("test busy done");
      cmd(AUTOSAVE_ON_CMD, 17'h0, 8'h00, 8'h00, 1'b1);
      chk("autosave", 8'h00, {7'h0, autosave_o});
      cmd(SET_WRITE_LATCH_CMD, 17'h0, 8'h00, 8'h00, 1'b1);
      cmd(AUTOSAVE_ON_CMD, 17'h0, 8'h00, 8'h00, 1'b1);
      chk("autosave", 8'h01, {7'h0, autosave_o});
      chk("status", 8'hC4, status_o);
      cmd(SET_WRITE_LATCH_CMD, 17'h0, 8'h00, 8'h00, 1'b1);
      cmd(STATUS_WRITE_CMD, 17'h0, 8'h01, 8'h00, 1'b1);
      chk("status", 8'h40, status_o);
      cmd(SET_WRITE_LATCH_CMD, 17'h0, 8'h00, 8'h00, 1'b1);
      cmd(RECALL_CMD, 17'h0, 8'h00, 8'h00, 1'b1);
      chk("status", 8'hC4, status_o);
      $display("test recall done");
      results();
   end
endmodule // tb_top
`default_nettype wire

// *** verilog/snv_dev.sv ***
// Device end: serial command logic, status register and array
//
// Chosen here: the clk_sys pin synchronisers and the direct write port to the array.
`timescale 1ns/1ps
`default_nettype none
module snv_dev import snv_pkg::*; (
   input wire logic clk_sys,
   input wire logic rstn,
   snv_link_if.dev link,
   input wire logic mem_we,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   input wire logic busy_in,
   output logic [7:0] status_o,
   output logic [7:0] nv_status_o,
   output logic autosave_o
);
   // ==========================================================
   // Pin synchronisers
   logic [3:0] pin_s1_q, pin_s2_q;
   logic sck_prev_q, cs_prev_q;
   wire logic [3:0] pin_raw = {link.cs_n, link.sck, link.si, link.wp_n};
   wire logic cs_n_s = pin_s2_q[3];
   wire logic sck_s = pin_s2_q[2];
   wire logic si_s = pin_s2_q[1];
   wire logic wp_s = pin_s2_q[0];
   wire logic sck_rise = ~cs_n_s & sck_s & ~sck_prev_q;
   wire logic sck_fall = ~cs_n_s & ~sck_s & sck_prev_q;
   wire logic cs_rise = cs_n_s & ~cs_prev_q;

   // ==========================================================
   // State
   snv_dst_t st_q, st_d;
   logic [2:0] bit_q, bit_d, obit_q, obit_d;
   logic [1:0] abyte_q, abyte_d;
   logic [7:0] sh_q, sh_d, out_q, out_d, pend_q, pend_d, nv_q, nv_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic fast_q, fast_d, rd_sr_q, rd_sr_d, sr_ok_q, sr_ok_d;
   logic wen_q, wen_d, pin_en_q, pin_en_d, lock_q, lock_d;
   logic [1:0] blk_q, blk_d;
   logic asave_q, asave_d, busy_q, so_q, so_d, oe_q, oe_d;
   logic [7:0] mem_q [MEM_DEPTH];

   // ==========================================================
   // Decode
   wire logic [7:0] byte_in = {sh_q[6:0], si_s};
   wire logic byte_done = sck_rise & (bit_q == 3'd7);
   wire logic [7:0] sr_byte = {pin_en_q, lock_q, 2'b00, blk_q, wen_q, busy_q};
   wire logic wr_class = (byte_in == MEM_WRITE_CMD) |
      (byte_in == CLOCK_REGISTER_WRITE_CMD) |
      (byte_in == SERIAL_NUMBER_WRITE_CMD) | (byte_in == STORE_CMD) |
      (byte_in == RECALL_CMD) | (byte_in == AUTOSAVE_ON_CMD) |
      (byte_in == AUTOSAVE_OFF_CMD);
   wire logic [ADDR_W-1:0] addr_nxt = ADDR_W'(addr_q + 1'b1);
   // low address byte completes the address
   wire logic [ADDR_W-1:0] addr_new = {addr_q[16:8], byte_in};
   wire logic [7:0] rd_first = mem_q[addr_new];
   wire logic [7:0] rd_cur = mem_q[addr_q];
   wire logic [7:0] rd_next = rd_sr_q ? sr_byte : mem_q[addr_nxt];
   wire logic prot_hit = (blk_q == 2'b11) |
      ((blk_q == 2'b10) & (mem_addr >= PROT_HALF)) |
      ((blk_q == 2'b01) & (mem_addr >= PROT_QUARTER));

   // ==========================================================
   // Next state
   always_comb begin
      st_d = st_q;
      bit_d = bit_q;
      obit_d = obit_q;
      abyte_d = abyte_q;
      sh_d = sh_q;
      out_d = out_q;
      addr_d = addr_q;
      fast_d = fast_q;
      rd_sr_d = rd_sr_q;
      sr_ok_d = sr_ok_q;
      wen_d = wen_q;
      pend_d = pend_q;
      pin_en_d = pin_en_q;
      lock_d = lock_q;
      blk_d = blk_q;
      nv_d = nv_q;
      asave_d = asave_q;
      so_d = so_q;
      oe_d = oe_q;
      if (cs_n_s) begin
         st_d = DS_OP;
         bit_d = 3'd0;
         abyte_d = 2'd0;
         oe_d = 1'b0;
         if (cs_rise) begin
            // latch cleared as the frame ends
            if (pend_q != NO_CMD) begin
               wen_d = 1'b0;
            end
            case (pend_q)
               STORE_CMD: begin
                  nv_d = sr_byte & SR_NV_MASK;
               end
               RECALL_CMD: begin
                  pin_en_d = nv_q[SR_PIN_EN];
                  lock_d = lock_q | nv_q[SR_LOCK];
                  blk_d = nv_q[SR_BLOCK_HI:SR_BLOCK_LO];
               end
               AUTOSAVE_ON_CMD: asave_d = 1'b1;
               AUTOSAVE_OFF_CMD: asave_d = 1'b0;
               default: ;
            endcase
            pend_d = NO_CMD;
         end
      end else begin
         if (sck_rise) begin
            sh_d = byte_in;
            bit_d = bit_q + 3'd1;
         end
         if (byte_done) begin
            case (st_q)
               DS_OP: begin
                  st_d = DS_IGN;
                  rd_sr_d = 1'b0;
                  if (byte_in == READ_CMD || byte_in == FAST_READ_CMD) begin
                     st_d = DS_ADDR;
                     fast_d = (byte_in == FAST_READ_CMD);
                  end else if (byte_in == STATUS_READ_CMD) begin
                     st_d = DS_DATA;
                     rd_sr_d = 1'b1;
                     out_d = sr_byte;
                     obit_d = 3'd0;
                  end else if (byte_in == SET_WRITE_LATCH_CMD) begin
                     wen_d = 1'b1;
                  end else if (byte_in == CLEAR_WRITE_LATCH_CMD) begin
                     pend_d = byte_in;
                  end else if (byte_in == STATUS_WRITE_CMD && wen_q) begin
                     st_d = DS_SRWR;
                     sr_ok_d = ~(pin_en_q & ~wp_s);
                  end else if (wr_class && wen_q) begin
                     pend_d = byte_in;
                  end
                  // latch clear leaves other commands in DS_IGN
               end
               DS_ADDR: begin
                  abyte_d = abyte_q + 2'd1;
                  case (abyte_q)
                     2'd0: addr_d[16] = byte_in[0];
                     2'd1: addr_d[15:8] = byte_in;
                     default: begin
                        addr_d = addr_new;
                        obit_d = 3'd0;
                        if (fast_q) begin
                           st_d = DS_DUMMY;
                        end else begin
                           st_d = DS_DATA;
                           out_d = rd_first;
                        end
                     end
                  endcase
               end
               DS_DUMMY: begin
                  st_d = DS_DATA;
                  out_d = rd_cur;
               end
               DS_SRWR: begin
                  if (sr_ok_q) begin
                     pin_en_d = byte_in[SR_PIN_EN];
                     blk_d = byte_in[SR_BLOCK_HI:SR_BLOCK_LO];
                     lock_d = lock_q | byte_in[SR_LOCK];
                  end
                  pend_d = STATUS_WRITE_CMD;
                  st_d = DS_IGN;
               end
               default: ;
            endcase
         end
         if (sck_fall && st_q == DS_DATA) begin
            so_d = out_q[7];
            oe_d = 1'b1;
            out_d = {out_q[6:0], 1'b0};
            obit_d = obit_q + 3'd1;
            if (obit_q == 3'd7) begin
               out_d = rd_next;
               if (!rd_sr_q) begin
                  addr_d = addr_nxt;
               end
            end
         end
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         pin_s1_q <= PIN_IDLE;
         pin_s2_q <= PIN_IDLE;
         sck_prev_q <= 1'b0;
         cs_prev_q <= 1'b1;
      end else begin
         pin_s1_q <= pin_raw;
         pin_s2_q <= pin_s1_q;
         sck_prev_q <= sck_s;
         cs_prev_q <= cs_n_s;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         st_q <= DS_OP;
         {bit_q, obit_q, abyte_q} <= 8'h00;
         {sh_q, out_q, pend_q} <= 24'h000000;
         addr_q <= 17'h00000;
         {fast_q, rd_sr_q, sr_ok_q} <= 3'h0;
      end else begin
         st_q <= st_d;
         {bit_q, obit_q, abyte_q} <= {bit_d, obit_d, abyte_d};
         {sh_q, out_q, pend_q} <= {sh_d, out_d, pend_d};
         addr_q <= addr_d;
         {fast_q, rd_sr_q, sr_ok_q} <= {fast_d, rd_sr_d, sr_ok_d};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         wen_q <= 1'b0;
         {pin_en_q, lock_q, blk_q} <= 4'h0;
         nv_q <= SR_RESET;
         {asave_q, busy_q, so_q, oe_q} <= 4'h0;
      end else begin
         wen_q <= wen_d;
         {pin_en_q, lock_q, blk_q} <= {pin_en_d, lock_d, blk_d};
         nv_q <= nv_d;
         {asave_q, busy_q, so_q, oe_q} <= {asave_d, busy_in, so_d, oe_d};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (mem_we && !prot_hit) begin
         mem_q[mem_addr] <= mem_wdata;
      end
   end

   assign link.so_o = so_q;
   assign link.so_oe = oe_q;
   assign link.store_busy = busy_q;
   assign status_o = sr_byte;
   assign nv_status_o = nv_q;
   assign autosave_o = asave_q;
endmodule // snv_dev
`default_nettype wire

// *** verilog/snv_host.sv ***
// Host end: APB-programmed serial master for the nvSRAM
`timescale 1ns/1ps
`default_nettype none
module snv_host import snv_pkg::*; (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   snv_link_if.host link,
   output logic [7:0] rx_byte,
   output logic rx_stb
);
   // ==========================================================
   // Registers
   logic [7:0] op_q, len_q, tx_q, rx_q, sh_q, rsh_q, div_q;
   logic [ADDR_W-1:0] addr_q;
   logic [8:0] bidx_q, tot_q, ds_q;
   logic [2:0] bit_q;
   logic [1:0] so_sy_q, sb_sy_q;
   logic start_q, done_q, wp_q, cs_q, sck_q, si_q, stb_q;
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q;
   snv_hst_t st_q;

   // ==========================================================
   // APB decode
   wire logic setup = psel & ~penable;
   wire logic wr = psel & penable & pready_q & pwrite;
   wire logic busy = (st_q != HS_IDLE) | start_q;
   wire logic hit = (paddr == REG_CTRL) | (paddr == REG_ADDR) |
      (paddr == REG_TXDATA) | (paddr == REG_RXDATA) |
      (paddr == REG_STAT) | (paddr == REG_PINS);
   wire logic [31:0] rd_mux =
      (paddr == REG_CTRL) ? {16'h0000, len_q, op_q} :
      (paddr == REG_ADDR) ? {15'h0000, addr_q} :
      (paddr == REG_TXDATA) ? {24'h000000, tx_q} :
      (paddr == REG_RXDATA) ? {24'h000000, rx_q} :
      (paddr == REG_STAT) ? {29'h0, sb_sy_q[1], done_q, busy} :
      (paddr == REG_PINS) ? {31'h0, wp_q} : 32'h00000000;
   wire logic go = wr & (paddr == REG_CTRL) & pwdata[CTRL_START] & ~busy;

   // ==========================================================
   // Frame shaping
   // read opcodes decoded
   wire logic is_rd = (op_q == READ_CMD) | (op_q == FAST_READ_CMD);
   wire logic is_fast = op_q == FAST_READ_CMD;
   wire logic [8:0] ds = 9'd1 + (is_rd ? 9'd3 : 9'd0) + (is_fast ? 9'd1 : 9'd0);
   // memory reads wait out a store
   wire logic hold = is_rd & sb_sy_q[1];
   // fixed divider, far below read limit
   wire logic half_done = div_q == SCK_HALF_CYC - 8'd1;
   wire logic [8:0] nidx = bidx_q + 9'd1;
   // status write carries one data byte
   wire logic [7:0] nbyte =
      (is_rd && nidx == 9'd1) ? {7'h00, addr_q[16]} :
      (is_rd && nidx == 9'd2) ? addr_q[15:8] :
      (is_rd && nidx == 9'd3) ? addr_q[7:0] :
      (op_q == STATUS_WRITE_CMD) ? tx_q : 8'h00;
   wire logic [7:0] rsh_nx = {rsh_q[6:0], so_sy_q[1]};

   // ==========================================================
   // APB slave, zero wait states
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         {pready_q, pslverr_q} <= 2'b00;
         prdata_q <= 32'h00000000;
         {op_q, len_q, tx_q} <= 24'h000000;
         addr_q <= 17'h00000;
         wp_q <= WP_RESET;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup & ~hit;
         if (setup) begin
            prdata_q <= hit && !pwrite ? rd_mux : 32'h00000000;
         end
         if (wr && paddr == REG_CTRL && !busy) begin
            op_q <= pwdata[7:0];
            len_q <= pwdata[CTRL_LEN_LSB +: 8];
         end
         if (wr && paddr == REG_ADDR && !busy) begin
            addr_q <= pwdata[ADDR_W-1:0];
         end
         if (wr && paddr == REG_TXDATA && !busy) begin
            tx_q <= pwdata[7:0];
         end
         if (wr && paddr == REG_PINS) begin
            wp_q <= pwdata[0];
         end
      end
   end

   // ==========================================================
   // Serial engine, mode 0, MSB first
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         st_q <= HS_IDLE;
         {cs_q, sck_q, si_q} <= 3'b100;
         {start_q, done_q, stb_q} <= 3'b000;
         {sh_q, rsh_q, rx_q, div_q} <= 32'h00000000;
         {bidx_q, tot_q, ds_q} <= 27'h0;
         bit_q <= 3'd0;
         {so_sy_q, sb_sy_q} <= 4'h0;
      end else begin
         so_sy_q <= {so_sy_q[0], link.so};
         sb_sy_q <= {sb_sy_q[0], link.store_busy};
         stb_q <= 1'b0;
         div_q <= half_done ? 8'h00 : div_q + 8'd1;
         case (st_q)
            HS_IDLE: begin
               div_q <= 8'h00;
               if (go) begin
                  start_q <= 1'b1;
                  done_q <= 1'b0;
               end else if (start_q && !hold) begin
                  start_q <= 1'b0;
                  cs_q <= 1'b0;
                  si_q <= op_q[7];
                  sh_q <= {op_q[6:0], 1'b0};
                  {bidx_q, bit_q} <= 12'h000;
                  ds_q <= ds;
                  tot_q <= ds + {1'b0, len_q} - 9'd1;
                  st_q <= HS_LOW;
               end
            end
            HS_LOW: if (half_done) begin
               sck_q <= 1'b1;
               rsh_q <= rsh_nx;
               st_q <= HS_HIGH;
            end
            HS_HIGH: if (half_done) begin
               sck_q <= 1'b0;
               bit_q <= bit_q + 3'd1;
               st_q <= HS_LOW;
               si_q <= sh_q[7];
               sh_q <= {sh_q[6:0], 1'b0};
               if (bit_q == 3'd7) begin
                  if (bidx_q >= ds_q) begin
                     rx_q <= rsh_q;
                     stb_q <= 1'b1;
                  end
                  if (bidx_q == tot_q) begin
                     st_q <= HS_END;
                  end
                  bidx_q <= nidx;
                  si_q <= nbyte[7];
                  sh_q <= {nbyte[6:0], 1'b0};
               end
            end
            HS_END: if (half_done) begin
               cs_q <= 1'b1;
               st_q <= HS_GAP;
            end
            HS_GAP: if (half_done) begin
               done_q <= 1'b1;
               st_q <= HS_IDLE;
            end
            default: st_q <= HS_IDLE;
         endcase
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign link.cs_n = cs_q;
   assign link.sck = sck_q;
   assign link.si = si_q;
   assign link.wp_n = wp_q;
   assign rx_byte = rx_q;
   assign rx_stb = stb_q;
endmodule // snv_host
`default_nettype wire

// *** verilog/snv_link_if.sv ***
// Serial link between host controller and nvSRAM device
`timescale 1ns/1ps
`default_nettype none
interface snv_link_if;
   logic cs_n;
   logic sck;
   logic si;
   logic wp_n;
   logic so_o;
   logic so_oe;
   logic store_busy;
   logic so;
   // Undriven output reads as zero, never floating
   assign so = so_oe ? so_o : 1'b0;
   modport dev (input cs_n, sck, si, wp_n, output so_o, so_oe, store_busy);
   modport host (output cs_n, sck, si, wp_n, input so, store_busy);
endinterface
`default_nettype wire

// *** verilog/snv_pkg.sv ***
// Shared constants and types for the serial nvSRAM link and both ends
package snv_pkg;
   // ==========================================================
   // Command opcodes
   localparam logic [7:0] READ_CMD = 8'h03;
   localparam logic [7:0] FAST_READ_CMD = 8'h0B;
   localparam logic [7:0] MEM_WRITE_CMD = 8'h02;
   localparam logic [7:0] CLOCK_REGISTER_WRITE_CMD = 8'h12;
   localparam logic [7:0] STORE_CMD = 8'h3C;
   localparam logic [7:0] RECALL_CMD = 8'h60;
   localparam logic [7:0] AUTOSAVE_ON_CMD = 8'h59;
   localparam logic [7:0] AUTOSAVE_OFF_CMD = 8'h19;
   localparam logic [7:0] SERIAL_NUMBER_WRITE_CMD = 8'hC2;
   localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
   localparam logic [7:0] STATUS_READ_CMD = 8'h05;
   localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
   localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
   localparam logic [7:0] NO_CMD = 8'h00;
   // ==========================================================
   // Status register layout
   localparam int SR_BUSY = 0;
   localparam int SR_WEN = 1;
   localparam int SR_BLOCK_LO = 2;
   localparam int SR_BLOCK_HI = 3;
   localparam int SR_LOCK = 6;
   localparam int SR_PIN_EN = 7;
   localparam logic [7:0] SR_RESET = 8'h00;
   localparam logic [7:0] SR_NV_MASK = 8'hCC;
   // ==========================================================
   // Array geometry and protected ranges
   localparam int ADDR_W = 17;
   localparam int MEM_DEPTH = 131072;
   localparam logic [16:0] PROT_QUARTER = 17'h18000;
   localparam logic [16:0] PROT_HALF = 17'h10000;
   // Idle pin levels {cs_n, sck, si, wp_n}
   localparam logic [3:0] PIN_IDLE = 4'h9;
   // ==========================================================
   // Host timing
   localparam int CLK_NS = 50;
   localparam int SCK_HALF_NS = 400;
   localparam logic [7:0] SCK_HALF_CYC = 8'(SCK_HALF_NS / CLK_NS);
   // ==========================================================
   // Host register map (byte offsets) and fields
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_TXDATA = 8'h08;
   localparam logic [7:0] REG_RXDATA = 8'h0C;
   localparam logic [7:0] REG_STAT = 8'h10;
   localparam logic [7:0] REG_PINS = 8'h14;
   localparam int CTRL_LEN_LSB = 8;
   localparam int CTRL_START = 16;
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
   localparam int STAT_STORE = 2;
   localparam logic WP_RESET = 1'b1;
   // ==========================================================
   // State machines
   typedef enum logic [2:0] {
      DS_OP = 3'b000,
      DS_ADDR = 3'b001,
      DS_DUMMY = 3'b011,
      DS_DATA = 3'b010,
      DS_SRWR = 3'b110,
      DS_IGN = 3'b111
   } snv_dst_t;
   typedef enum logic [2:0] {
      HS_IDLE = 3'b000,
      HS_LOW = 3'b001,
      HS_HIGH = 3'b011,
      HS_END = 3'b010,
      HS_GAP = 3'b110
   } snv_hst_t;
endpackage
